// *** uef_cfg.svh ***
`ifndef UEF_CFG_SVH
`define UEF_CFG_SVH

// Register byte offsets on the Avalon slave, one aligned word each.
`define UEF_OFS_FLAGS 6'h00
`define UEF_OFS_MASK 6'h04
`define UEF_OFS_ERR_FLAGS 6'h08
`define UEF_OFS_ERR_EN 6'h0c
`define UEF_OFS_XFER_STAT 6'h10
`define UEF_OFS_CTRL 6'h14

// Field positions inside the event flag register.
`define UEF_BIT_STALL 7
`define UEF_BIT_ATTACH 6
`define UEF_BIT_RESUME 5
`define UEF_BIT_IDLE 4
`define UEF_BIT_TOKEN 3
`define UEF_BIT_SOF 2
`define UEF_BIT_ERR 1
`define UEF_BIT_RESET 0

// Field positions inside the control and transfer status registers.
`define UEF_BIT_HOST_EN 0
`define UEF_BIT_STAT_VALID 0
`define UEF_BIT_STAT_DIR 3
`define UEF_STAT_EP_LSB 4

// Reset values.
`define UEF_FLAGS_RST 8'h00
`define UEF_MASK_RST 8'h00
`define UEF_ERR_EN_RST 8'h00
`define UEF_RDATA_RST 32'h0000_0000

// Timing: clock period, line hold time and idle time.
`define UEF_CLK_PERIOD_NS 100
`define UEF_LINE_HOLD_NS 2500
`define UEF_IDLE_MS 3
`define UEF_LINE_HOLD_CYC ((`UEF_LINE_HOLD_NS + `UEF_CLK_PERIOD_NS - 1) / `UEF_CLK_PERIOD_NS)
`define UEF_IDLE_CYC ((`UEF_IDLE_MS * 1000000 + `UEF_CLK_PERIOD_NS - 1) / `UEF_CLK_PERIOD_NS)

// Transfer status queue geometry.
`define UEF_FIFO_AW 2
`define UEF_FIFO_DEPTH 4
`define UEF_STAT_W 5

`endif

// *** uef_pkg.sv ***
`include "uef_cfg.svh"

package uef_pkg;

    // State of the top module except its timers and status memory, registered as one word.
    typedef struct packed {
        logic [1:0] dp_sync;
        logic [1:0] dm_sync;
        logic [1:0] line_prev;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] err_flags;
        logic [7:0] err_en;
        logic host_en;
        logic attached;
        logic [`UEF_FIFO_AW-1:0] wr_ptr;
        logic [`UEF_FIFO_AW-1:0] rd_ptr;
        logic [`UEF_FIFO_AW:0] count;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
    } uef_state_t;

endpackage

// *** uef_persist.sv ***
`timescale 1ns/100ps

// Pulses once when a condition has held for CNT consecutive cycles.
module uef_persist #(
    parameter int CNT = 25
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cond,
    output logic hit
);

    localparam int W = $clog2(CNT + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic hit;
    } uef_persist_t;

    uef_persist_t s_r;
    uef_persist_t s_nxt;

    // The count saturates so that a long episode gives one pulse only.
    always_comb begin
        s_nxt = s_r;
        s_nxt.hit = 1'b0;
        if (!cond) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt < W'(CNT)) begin
            s_nxt.cnt = s_r.cnt + W'(1);
            s_nxt.hit = (s_r.cnt == W'(CNT - 1));
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hit = s_r.hit;

endmodule

// *** uef_stat_mem.sv ***
`timescale 1ns/100ps

// Small storage for transfer status entries with registered read data.
module uef_stat_mem #(
    parameter int AW = 2,
    parameter int W = 5
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);

    typedef struct packed {
        logic [(1<<AW)-1:0][W-1:0] mem;
        logic [W-1:0] rd;
    } uef_mem_t;

    uef_mem_t s_r;
    uef_mem_t s_nxt;

    // A write to the address being read is passed through, so a fresh entry is never stale.
    always_comb begin
        s_nxt = s_r;
        if (wr_en) begin
            s_nxt.mem[wr_addr] = wr_data;
        end
        if (wr_en && (wr_addr == rd_addr)) begin
            s_nxt.rd = wr_data;
        end else begin
            s_nxt.rd = s_r.mem[rd_addr];
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data = s_r.rd;

endmodule

// *** uef_top.sv ***
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`include "uef_cfg.svh"

// How it works
// - In host role, a received stall handshake sets the stall flag.
// - In function role, a transmitted stall handshake sets the stall flag.
// - Detecting a peripheral attaching sets the attach flag.
// - Attach counts only in host role, after quiet line time, line not SE0.
// - K state held 2.5 us on the data lines sets the resume flag.
// - Unbroken idle line for 3 ms or more sets the idle flag.
// - Token completion sets token-done; transfer status shows the endpoint.
// - Clearing token-done advances the transfer status queue.
// - SOF received as function, or host SOF threshold, sets the SOF flag.
// - Error summary is read-only, set only by enabled error conditions.
// - In function role the lowest flag reports a valid bus reset.
// - In host role the lowest flag reports a peripheral detach.
// - Flags set by hardware, cleared by writing one; all reset to zero.
// - Flag register bits 31 to 8 always read zero.
module uef_top #(
    parameter int IDLE_CYC = `UEF_IDLE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic usb_dp_in,
    input wire logic usb_dm_in,
    input wire logic stall_rx_evt,
    input wire logic stall_tx_evt,
    input wire logic tok_done_evt,
    input wire logic [3:0] tok_ep,
    input wire logic tok_dir,
    input wire logic sof_rx_evt,
    input wire logic sof_thresh_evt,
    input wire logic [7:0] err_evt,
    output logic host_role_enable,
    output logic irq
);

    localparam int HOLD_CYC = `UEF_LINE_HOLD_CYC;
    localparam logic [`UEF_FIFO_AW:0] FIFO_FULL = (`UEF_FIFO_AW + 1)'(`UEF_FIFO_DEPTH);

    // Register map, one aligned 32-bit word per register:
    //   0x00 event flags, write one to clear; bit 1 is the live error summary.
    //   0x04 interrupt mask, same layout as the event flags.
    //   0x08 error flags, write one to clear.
    //   0x0c error enable, choosing which error flags feed the summary.
    //   0x10 transfer status, read only: endpoint, direction, not-empty bit.
    //   0x14 control; bit 0 selects the host role.
    // Any other address reads as zero and ignores writes.
    // Only byte lane 0 holds register bits, so a write without it is ignored.

    // Bus timing: waitrequest idles high. A request seen while it is high is
    // taken, and waitrequest then drops for exactly one cycle with the read
    // data already standing. A write is committed on that low cycle, at the
    // edge where the master completes. Every access costs two cycles, and the
    // master may start the next one in the cycle after it lets go.
    // Reads have no side effects, so their data is loaded at the taking edge.
    // The answer never waits on anything else, so a request cannot hang.

    // Line detection: the data lines pass two flip-flops first, so every line
    // event lags the pins by two cycles. Each timer fires once per unbroken
    // episode and must see its condition drop before it can fire again.
    // A line that changes every cycle never lets a timer run out, which is
    // how ongoing bus traffic looks to this block.
    // The J, K and SE0 decodes assume full-speed signalling levels.

    // Role switching: the stall, SOF and lowest-flag sources follow the role
    // bit as it stands, so an event in the cycle of a role write follows the
    // old role. Leaving the host role forgets any attached peripheral.

    // Detach is only reported after an attach was seen, so an empty port held
    // in SE0 does not keep reporting detach in the host role.

    // Transfer status queue: each finished token pushes its endpoint and
    // direction. A full queue drops the new entry but still raises token-done,
    // so software learns that a token finished even if its detail is lost.
    // Clearing token-done pops the head; if more entries wait, the flag is
    // raised again in the same cycle so that none is overlooked.
    // The queue is four deep; its storage lives in its own small memory.

    // The interrupt is a level: it stays high while any unmasked flag is set,
    // the error summary included, and falls only when software clears or masks.

    // Limitations: the idle time is counted in clock cycles, so IDLE_CYC must
    // match the real clock, while the line hold time comes from the header.
    // A hardware set in the commit cycle of a clearing write leaves the flag
    // set, so an event is never lost to a badly timed clear.
    // Error sources are pulses; each sets its own sticky error flag whether
    // or not it is enabled, and enabling it later raises the summary at once.

    // Event inputs come from logic on this clock and are used as they are;
    // only the two line pins cross in from outside and need synchronising.

    uef_pkg::uef_state_t s_r;
    uef_pkg::uef_state_t s_nxt;

    logic dp_s;
    logic dm_s;
    logic se0;
    logic line_j;
    logic line_k;
    logic quiet;
    logic [2:0] hold_cond;
    logic [2:0] hold_hit;
    logic idle_hit;
    logic [`UEF_STAT_W-1:0] stat_head;
    logic [`UEF_FIFO_AW-1:0] stat_rd_addr;
    logic push;
    logic pop;

    // Address match, used by the write decoder; the read decoder uses a case.
    function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    // Line state after the two-stage synchronisers; only stage two is used.
    assign dp_s = s_r.dp_sync[1];
    assign dm_s = s_r.dm_sync[1];
    assign se0 = !dp_s && !dm_s;
    assign line_j = dp_s && !dm_s;
    assign line_k = !dp_s && dm_s;
    // A driven, unchanging line counts as quiet; any edge restarts the wait.
    assign quiet = (line_j || line_k) && ({dp_s, dm_s} == s_r.line_prev);

    // Conditions that must persist for the line hold time.
    assign hold_cond[0] = line_k;
    assign hold_cond[1] = quiet;
    assign hold_cond[2] = se0;

    // One persistence timer per line condition that shares the hold time.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_hold
            uef_persist #(
                .CNT(HOLD_CYC)
            ) u_hold (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .cond(hold_cond[gi]),
                .hit(hold_hit[gi])
            );
        end
    endgenerate

    // The idle time is long, so its count is a top parameter.
    uef_persist #(
        .CNT(IDLE_CYC)
    ) u_idle (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cond(line_j),
        .hit(idle_hit)
    );

    // Transfer status entries waiting for software.
    uef_stat_mem #(
        .AW(`UEF_FIFO_AW),
        .W(`UEF_STAT_W)
    ) u_stat (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_en(push),
        .wr_addr(s_r.wr_ptr),
        .wr_data({tok_ep, tok_dir}),
        .rd_addr(stat_rd_addr),
        .rd_data(stat_head)
    );

    // Flags as software sees them, with the live error summary folded in.
    function automatic logic [7:0] flag_view(input logic [7:0] flags, input logic summary);
        logic [7:0] v;
        v = flags;
        v[`UEF_BIT_ERR] = summary;
        flag_view = v;
    endfunction

    logic acc;
    logic wr_lo;
    logic [7:0] clr;
    logic [7:0] ev_set;
    logic err_sum_nxt;

    // Bus access, event collection and the status queue pointers.
    always_comb begin
        s_nxt = s_r;
        s_nxt.dp_sync = {s_r.dp_sync[0], usb_dp_in};
        s_nxt.dm_sync = {s_r.dm_sync[0], usb_dm_in};
        s_nxt.line_prev = {dp_s, dm_s};

        // A request is taken when it meets the wait state; the answer follows one cycle later.
        acc = (avs_read || avs_write) && s_r.waitreq;
        // A write lands only at the edge where the master sees waitrequest low,
        // so nothing changes before the master has had its answer.
        wr_lo = avs_write && !s_r.waitreq && avs_byteenable[0];
        clr = 8'h00;
        if (wr_lo && reg_hit(avs_address, `UEF_OFS_FLAGS)) begin
            clr = avs_writedata[7:0];
        end

        // Hardware events; stall, attach, SOF and the lowest flag follow the current role.
        ev_set = 8'h00;
        ev_set[`UEF_BIT_STALL] = s_r.host_en ? stall_rx_evt : stall_tx_evt;
        ev_set[`UEF_BIT_ATTACH] = s_r.host_en && !s_r.attached && hold_hit[1];
        ev_set[`UEF_BIT_RESUME] = hold_hit[0];
        ev_set[`UEF_BIT_IDLE] = idle_hit;
        ev_set[`UEF_BIT_SOF] = s_r.host_en ? sof_thresh_evt : sof_rx_evt;
        ev_set[`UEF_BIT_RESET] = hold_hit[2] && (s_r.host_en ? s_r.attached : 1'b1);

        // Clearing token-done drops the head entry; more entries raise the flag again.
        pop = clr[`UEF_BIT_TOKEN] && s_r.flags[`UEF_BIT_TOKEN] && (s_r.count != '0);
        push = tok_done_evt && (s_r.count != FIFO_FULL);
        ev_set[`UEF_BIT_TOKEN] = tok_done_evt || (pop && (s_r.count > (`UEF_FIFO_AW + 1)'(1)));

        // Set wins over clear; the summary bit is never stored.
        s_nxt.flags = (s_r.flags & ~clr) | ev_set;
        s_nxt.flags[`UEF_BIT_ERR] = 1'b0;

        // Attachment state follows the detector while in host role.
        if (!s_r.host_en) begin
            s_nxt.attached = 1'b0;
        end else if (ev_set[`UEF_BIT_ATTACH]) begin
            s_nxt.attached = 1'b1;
        end else if (ev_set[`UEF_BIT_RESET]) begin
            s_nxt.attached = 1'b0;
        end

        // Queue pointers; the read address looks ahead so the head is ready at once.
        if (push) begin
            s_nxt.wr_ptr = s_r.wr_ptr + `UEF_FIFO_AW'(1);
        end
        if (pop) begin
            s_nxt.rd_ptr = s_r.rd_ptr + `UEF_FIFO_AW'(1);
        end
        case ({push, pop})
            2'b10: s_nxt.count = s_r.count + (`UEF_FIFO_AW + 1)'(1);
            2'b01: s_nxt.count = s_r.count - (`UEF_FIFO_AW + 1)'(1);
            default: s_nxt.count = s_r.count;
        endcase

        // Error flags are sticky and cleared by writing one, set winning.
        s_nxt.err_flags = s_r.err_flags | err_evt;
        if (wr_lo && reg_hit(avs_address, `UEF_OFS_ERR_FLAGS)) begin
            s_nxt.err_flags = (s_r.err_flags & ~avs_writedata[7:0]) | err_evt;
        end
        if (wr_lo && reg_hit(avs_address, `UEF_OFS_ERR_EN)) begin
            s_nxt.err_en = avs_writedata[7:0];
        end
        if (wr_lo && reg_hit(avs_address, `UEF_OFS_MASK)) begin
            s_nxt.mask = avs_writedata[7:0];
        end
        if (wr_lo && reg_hit(avs_address, `UEF_OFS_CTRL)) begin
            s_nxt.host_en = avs_writedata[`UEF_BIT_HOST_EN];
        end
        err_sum_nxt = |(s_nxt.err_flags & s_nxt.err_en);

        // Read data are loaded at the accept edge; unmapped reads give zero.
        s_nxt.waitreq = !acc;
        if (acc && avs_read) begin
            s_nxt.rdata = `UEF_RDATA_RST;
            case (avs_address)
                `UEF_OFS_FLAGS: s_nxt.rdata[7:0] = flag_view(s_r.flags, |(s_r.err_flags & s_r.err_en));
                `UEF_OFS_MASK: s_nxt.rdata[7:0] = s_r.mask;
                `UEF_OFS_ERR_FLAGS: s_nxt.rdata[7:0] = s_r.err_flags;
                `UEF_OFS_ERR_EN: s_nxt.rdata[7:0] = s_r.err_en;
                `UEF_OFS_XFER_STAT: begin
                    s_nxt.rdata[`UEF_STAT_EP_LSB +: 4] = stat_head[4:1];
                    s_nxt.rdata[`UEF_BIT_STAT_DIR] = stat_head[0];
                    s_nxt.rdata[`UEF_BIT_STAT_VALID] = (s_r.count != '0);
                end
                `UEF_OFS_CTRL: s_nxt.rdata[`UEF_BIT_HOST_EN] = s_r.host_en;
                default: s_nxt.rdata = `UEF_RDATA_RST;
            endcase
        end

        // Level interrupt from the next flag view, so it leaves a flip-flop.
        s_nxt.irq = |(flag_view(s_nxt.flags, err_sum_nxt) & s_nxt.mask);
    end

    assign stat_rd_addr = s_nxt.rd_ptr;

    // State register with synchronous reset; all flags start clear.
    // Waitrequest comes out of reset high, so no access is answered during it.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.flags <= `UEF_FLAGS_RST;
            s_r.mask <= `UEF_MASK_RST;
            s_r.err_en <= `UEF_ERR_EN_RST;
            s_r.waitreq <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.waitreq;
    assign host_role_enable = s_r.host_en;
    assign irq = s_r.irq;

endmodule

// *** uef_checker.sv ***
`timescale 1ns/100ps

// Port-level checks of the register bus and the flag outputs.
module uef_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic host_role_enable,
    input wire logic irq
);
    // One domain, so clock and reset are given once for all checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered next cycle");
    AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_IDLE_WAIT: assert property (!avs_read && !avs_write && avs_waitrequest
        |=> avs_waitrequest) else $error("answer without a request");
    AST_UPPER_ZERO: assert property (
        avs_read && avs_waitrequest && avs_address == 6'h00
        |=> avs_readdata[31:8] == 24'h0) else $error("flag upper bits set");
    AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address > 6'h14
        |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_HOST_SET: assert property (avs_write && avs_waitrequest && avs_address == 6'h14
        && avs_byteenable[0] && avs_writedata[0] |-> ##[1:2] host_role_enable)
        else $error("host role not enabled");
    AST_HOST_CLR: assert property (avs_write && avs_waitrequest && avs_address == 6'h14
        && avs_byteenable[0] && !avs_writedata[0] |-> ##[1:2] !host_role_enable)
        else $error("host role not disabled");
    AST_HOST_HOLD: assert property ($changed(host_role_enable)
        |-> $past(avs_write) || $past(avs_write, 2)) else $error("role changed alone");
    AST_IRQ_DROP: assert property ($fell(irq)
        |-> $past(avs_write) || $past(avs_write, 2)) else $error("irq fell alone");
endmodule

bind uef_top uef_checker i_uef_checker (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .host_role_enable(host_role_enable), .irq(irq));

// *** uef_line_model.sv ***
`timescale 1ns/100ps

// Far-side bus model: mode 0 toggles J and K, 1 holds J, 2 holds K, 3 holds SE0.
module uef_line_model (
    input wire logic core_clk,
    input wire logic [1:0] mode,
    output logic dp,
    output logic dm
);
    logic tg = 1'b0;

    // Toggling each cycle stands for traffic, so no line timer can expire.
    always @(posedge core_clk) begin
        tg <= ~tg;
    end

    // Full-speed levels: J is dp high, K is dm high, SE0 is both low.
    assign dp = (mode == 2'h0) ? tg : (mode == 2'h1);
    assign dm = (mode == 2'h0) ? ~tg : (mode == 2'h2);
endmodule

// *** test_usb_event_flag_register.sv ***
`timescale 1ns/100ps

// Self-checking bench for the event flag register.
module test_usb_event_flag_register;
    typedef struct packed {logic h; logic [4:0] e; logic [7:0] f;} uef_row_t;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, usb_dp_in, usb_dm_in, host_role_enable, irq;
    logic [12:0] ev = 13'h0;
    logic [3:0] tok_ep = 4'h0;
    logic tok_dir = 1'b0;
    logic [1:0] line_mode = 2'h0;
    logic [31:0] q;
    int mismatches = 0;
    int check_count = 0;
    // Role, event pulse and expected flags; event bits are stall rx, stall tx,
    // token done, SOF rx and SOF threshold.
    uef_row_t rows [9] = '{
        '{1'b1, 5'h01, 8'h80}, '{1'b0, 5'h02, 8'h80},
        '{1'b0, 5'h01, 8'h00}, '{1'b1, 5'h02, 8'h00},
        '{1'b0, 5'h04, 8'h08}, '{1'b1, 5'h04, 8'h08},
        '{1'b0, 5'h08, 8'h04}, '{1'b1, 5'h10, 8'h04},
        '{1'b0, 5'h10, 8'h00}};

    uef_top #(.IDLE_CYC(50)) i_uef_top (.core_clk(core_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .usb_dp_in(usb_dp_in), .usb_dm_in(usb_dm_in), .stall_rx_evt(ev[0]),
        .stall_tx_evt(ev[1]), .tok_done_evt(ev[2]), .tok_ep(tok_ep), .tok_dir(tok_dir),
        .sof_rx_evt(ev[3]), .sof_thresh_evt(ev[4]), .err_evt(ev[12:5]),
        .host_role_enable(host_role_enable), .irq(irq));
    uef_line_model i_uef_line_model (.core_clk(core_clk), .mode(line_mode),
        .dp(usb_dp_in), .dm(usb_dm_in));

    // Free-running 10 MHz clock.
    initial begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One bus cycle; the request stands until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask

    task automatic pulse(input logic [12:0] e);
        @(posedge core_clk);
        ev <= e;
        @(posedge core_clk);
        ev <= 13'h0;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // A hung handshake must not stall the run forever.
    initial begin
        #2000000;
        mismatches++;
        give_verdict;
    end

    // Main sequence: table rows first, then line events and corner cases.
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            wr(6'h14, {31'h0, rows[i].h});
            pulse({8'h0, rows[i].e});
            rd("flags", 6'h00, {24'h0, rows[i].f});
            wr(6'h00, 32'hffff_ffff);
            rd("cleared", 6'h00, 32'h0);
        end
        wr(6'h14, 32'h0);
        line_mode <= 2'h1;
        repeat (40) @(posedge core_clk);
        rd("idle early", 6'h00, 32'h0);
        repeat (20) @(posedge core_clk);
        rd("idle", 6'h00, 32'h10);
        line_mode <= 2'h2;
        repeat (30) @(posedge core_clk);
        rd("resume", 6'h00, 32'h30);
        line_mode <= 2'h3;
        repeat (30) @(posedge core_clk);
        rd("bus reset", 6'h00, 32'h31);
        line_mode <= 2'h0;
        wr(6'h00, 32'hff);
        wr(6'h14, 32'h1);
        line_mode <= 2'h2;
        repeat (30) @(posedge core_clk);
        rd("attach", 6'h00, 32'h60);
        line_mode <= 2'h3;
        repeat (30) @(posedge core_clk);
        rd("detach", 6'h00, 32'h61);
        line_mode <= 2'h0;
        wr(6'h00, 32'hff);
        // Two tokens queue up; each clear of token-done steps to the next.
        tok_ep <= 4'h5;
        tok_dir <= 1'b1;
        pulse(13'h4);
        tok_ep <= 4'h9;
        tok_dir <= 1'b0;
        pulse(13'h4);
        rd("status", 6'h10, 32'h59);
        wr(6'h00, 32'h08);
        rd("token again", 6'h00, 32'h08);
        rd("status next", 6'h10, 32'h91);
        wr(6'h00, 32'h08);
        bus(1'b0, 6'h10, 32'h0);
        chk("status empty", q & 32'h1, 32'h0);
        // Error summary follows only enabled error sources and ignores writes.
        pulse(13'h20);
        rd("err masked", 6'h00, 32'h0);
        wr(6'h08, 32'hff);
        wr(6'h0c, 32'h1);
        pulse(13'h20);
        wr(6'h00, 32'h02);
        rd("err summary", 6'h00, 32'h02);
        wr(6'h08, 32'hff);
        rd("err cleared", 6'h00, 32'h0);
        // Interrupt line, masking and write-zero behaviour.
        wr(6'h04, 32'h80);
        pulse(13'h1);
        repeat (2) @(posedge core_clk);
        chk("irq", irq, 32'h1);
        wr(6'h04, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("irq masked", irq, 32'h0);
        wr(6'h00, 32'h0);
        avs_byteenable <= 4'h0;
        wr(6'h00, 32'hff);
        avs_byteenable <= 4'hf;
        wr(6'h3c, 32'hff);
        rd("unmapped", 6'h3c, 32'h0);
        rd("kept", 6'h00, 32'h80);
        wr(6'h04, 32'h80);
        wr(6'h00, 32'h80);
        repeat (2) @(posedge core_clk);
        chk("irq cleared", irq, 32'h0);
        // A set in the clearing cycle must win.
        // The write commits two edges after it is raised; the event meets that edge.
        fork
            wr(6'h00, 32'h80);
            begin
                @(posedge core_clk);
                pulse(13'h1);
            end
        join
        rd("set wins", 6'h00, 32'h80);
        rd("role", 6'h14, 32'h1);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd("reset flags", 6'h00, 32'h0);
        rd("reset mask", 6'h04, 32'h0);
        chk("reset role", host_role_enable, 32'h0);
        chk("reset irq", irq, 32'h0);
        give_verdict;
    end
endmodule
